// file: hw/tag_directory.sv
`timescale 1ns/1ns
// How it works
// - Separate processor and snoop tag arrays, concurrent.
// - Processor array: 2048 entries, tag, context, flags.
// - Tag read alongside translation lookup, same address.
// - Virtual bits 15:5 select line and entry.
// - Hit when upper tag and context match.
// - Complete only with tag, translation, permission.
// - Reset clears every processor entry valid flag.
// - Snooped sharing sets the entry shared flag.
// - Access level 6 or 7 sets supervisor flag.
// - Supervisor lookup on supervisor entry skips context.
// - Bus array: 2048 entries, physical tag, flags.
// - Bus index: superset bits then physical bits.
// - Snoop hit needs tag match and valid.
// - Reset clears every bus entry valid flag.
// - Write-through mode sends every translated write to memory.
// - Copy-back holds changes until line replaced or flushed.
// - Bus entry flags encode five coherency states.
// - Modified line owner writes back, supplies data.
// - Exclusive clean sole copy; shared clean elsewhere too.
// - Processor entries: invalid, exclusive, shared valid.
// - Write-through uses valid only, ignores others.
// - Read fill exclusive if shared line high.
// - Coherent read hit: shared at A+2, mark shared.
module tag_directory
    import tag_dir_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic copy_back_mode,
    input wire logic proc_req,
    input wire logic [VA_W-1:0] proc_va,
    input wire logic proc_write,
    input wire logic proc_super,
    input wire logic [CTX_W-1:0] context_number,
    input wire logic tlb_hit,
    input wire logic tlb_perm_ok,
    input wire logic fill_req,
    input wire logic [VA_W-1:0] fill_va,
    input wire logic [PTAG_W-1:0] fill_pa_tag,
    input wire logic [CTX_W-1:0] fill_context,
    input wire logic [ACC_W-1:0] fill_acc_level,
    input wire logic fill_write,
    input wire logic fill_bus_shared_n,
    input wire logic flush_req,
    input wire logic [INDEX_W-1:0] flush_index,
    input wire logic snoop_req,
    input wire logic [MAD_W-1:0] snoop_mad,
    input wire logic [1:0] snoop_type,
    output logic proc_done,
    output logic proc_tag_hit,
    output logic proc_access_ok,
    output logic proc_line_shared,
    output logic mem_write_req,
    output logic line_invalidate_req,
    output logic writeback_req,
    output logic [INDEX_W-1:0] writeback_index,
    output logic snoop_done,
    output logic snoop_hit,
    output logic bus_shared_n,
    output logic snoop_owner,
    output logic [2:0] snoop_state
);

    // ------------------------------------------------------------
    // State flags, kept in flops so reset clears them at once
    // ------------------------------------------------------------
    logic [ENTRIES-1:0] p_valid;                // Processor valid flags
    logic [ENTRIES-1:0] p_shared;               // Processor shared_flag
    logic [ENTRIES-1:0] b_valid;                // Bus valid flags
    logic [ENTRIES-1:0] b_shared;               // Bus shared_flag
    logic [ENTRIES-1:0] b_modified;             // Bus modified flags

    // ------------------------------------------------------------
    // Fill decode
    // ------------------------------------------------------------
    wire [INDEX_W-1:0] fill_idx = fill_va[VA_IDX_HI:VA_IDX_LO];
    wire fill_super = (fill_acc_level == ACC_SUPER_A) || (fill_acc_level == ACC_SUPER_B);
    // shared line low means another holder
    wire fill_shared = copy_back_mode && !fill_write && (fill_bus_shared_n == MSH_ASSERTED);
    wire fill_modified = copy_back_mode && fill_write;
    // entry packs supervisor, context and tag
    wire [PENTRY_W-1:0] p_entry_wr = {fill_super, fill_context, fill_va[VA_TAG_HI:VA_TAG_LO]};

    // ------------------------------------------------------------
    // Tag arrays
    // ------------------------------------------------------------
    // line select picks the processor entry
    wire [INDEX_W-1:0] p_rd_idx = proc_va[VA_IDX_HI:VA_IDX_LO];
    // superset bits first, then physical bits
    wire [INDEX_W-1:0] b_rd_idx = {snoop_mad[MAD_SUPER_HI:MAD_SUPER_LO],
                                   snoop_mad[MAD_PIDX_HI:MAD_PIDX_LO]};
    logic [PENTRY_W-1:0] p_rd_data;             // Processor entry read
    logic [PTAG_W-1:0] b_rd_data;               // Bus entry read

    tag_mem #(.WIDTH(PENTRY_W), .DEPTH(ENTRIES), .AW(INDEX_W)) u_proc_virtual_tag_array (
        .sys_clk(sys_clk),
        .wr_en(fill_req),
        .wr_addr(fill_idx),
        .wr_data(p_entry_wr),
        .rd_addr(p_rd_idx),
        .rd_data(p_rd_data)
    );

    tag_mem #(.WIDTH(PTAG_W), .DEPTH(ENTRIES), .AW(INDEX_W)) u_bus_physical_tag_array (
        .sys_clk(sys_clk),
        .wr_en(fill_req),
        .wr_addr(fill_idx),
        .wr_data(fill_pa_tag),
        .rd_addr(b_rd_idx),
        .rd_data(b_rd_data)
    );

    // ------------------------------------------------------------
    // Processor lookup, stage one
    // ------------------------------------------------------------
    logic p1_vld;                               // Lookup in flight
    logic [INDEX_W-1:0] p1_idx;                 // Its line index
    logic [VTAG_W-1:0] p1_tag;                  // Its virtual tag
    logic [CTX_W-1:0] p1_ctx;                   // Context at request
    logic p1_super;                             // Supervisor access
    logic p1_write;                             // Write access

    // Capture request as the array read launches
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            p1_vld <= 1'h0;
            p1_idx <= '0;
            p1_tag <= '0;
            p1_ctx <= '0;
            p1_super <= 1'h0;
            p1_write <= 1'h0;
        end else begin
            p1_vld <= proc_req;
            p1_idx <= p_rd_idx;
            p1_tag <= proc_va[VA_TAG_HI:VA_TAG_LO];
            p1_ctx <= context_number;
            p1_super <= proc_super;
            p1_write <= proc_write;
        end
    end

    // upper address bits against stored tag
    wire p_tag_eq = p_rd_data[PE_TAG_HI:PE_TAG_LO] == p1_tag;
    // supervisor lookup on a supervisor entry forces the context match
    wire p_ctx_eq = (p_rd_data[PE_CTX_HI:PE_CTX_LO] == p1_ctx) ||
                    (p1_super && p_rd_data[PE_S_BIT]);
    wire p_hit = p1_vld && p_valid[p1_idx] && p_tag_eq && p_ctx_eq;
    // translation result arrives with the tag data
    wire tlb_ok = tlb_hit && tlb_perm_ok;
    wire p_ok = p_hit && tlb_ok;
    // write-through sends every translated write out
    wire wt_write = p1_vld && p1_write && tlb_ok && !copy_back_mode;
    // copy-back write hit stays local, marks modified
    wire cb_write_hit = p_ok && p1_write && copy_back_mode;
    // A shared line written here must be invalidated elsewhere
    wire cb_write_shared = cb_write_hit && b_shared[p1_idx];

    // ------------------------------------------------------------
    // Snoop lookup, stage one (cycle A+1)
    // ------------------------------------------------------------
    logic s1_vld;                               // Snoop in flight
    logic [INDEX_W-1:0] s1_idx;                 // Its line index
    logic [PTAG_W-1:0] s1_tag;                  // Its physical tag
    logic [1:0] s1_type;                        // Transaction kind

    // Capture the address phase
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_vld <= 1'h0;
            s1_idx <= '0;
            s1_tag <= '0;
            s1_type <= '0;
        end else begin
            s1_vld <= snoop_req;
            s1_idx <= b_rd_idx;
            s1_tag <= snoop_mad[PA_TAG_HI:PA_TAG_LO];
            s1_type <= snoop_type;
        end
    end

    // tag match and valid flag both needed
    wire s_hit = s1_vld && b_valid[s1_idx] && (b_rd_data == s1_tag);
    wire s_is_read = (s1_type == SNOOP_READ) || (s1_type == SNOOP_READ_INV);
    wire s_kill = s_hit && (s1_type != SNOOP_READ);
    wire s_share = s_hit && copy_back_mode && (s1_type == SNOOP_READ);
    // owner supplies the data of a modified line
    wire s_owner = s_hit && copy_back_mode && b_modified[s1_idx] && s_is_read;

    // ------------------------------------------------------------
    // Victim write-back on fill or flush
    // ------------------------------------------------------------
    wire [INDEX_W-1:0] evict_idx = fill_req ? fill_idx : flush_index;
    // memory updated only when a modified line leaves
    wire evict_dirty = (fill_req || flush_req) && copy_back_mode &&
                       b_valid[evict_idx] && b_modified[evict_idx];

    // ------------------------------------------------------------
    // State of the snooped line
    // ------------------------------------------------------------
    coh_state_t s_state;                        // Encoded line state

    always_comb begin
        s_state = COH_INVALID;
        if (!copy_back_mode) begin
            // only valid or invalid in write-through
            s_state = b_valid[s1_idx] ? COH_EXCL_CLEAN : COH_INVALID;
        end else begin
            case ({b_valid[s1_idx], b_shared[s1_idx], b_modified[s1_idx]})
                3'h4: s_state = COH_EXCL_CLEAN;
                3'h5: s_state = COH_EXCL_MOD;
                3'h6: s_state = COH_SHARED_CLEAN;
                3'h7: s_state = COH_SHARED_MOD;
                default: s_state = COH_INVALID;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flag updates; later statements win a same-cycle conflict
    // ------------------------------------------------------------
    // reset clears all valid flags
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            p_valid <= '0;
            p_shared <= '0;
            b_valid <= '0;
            b_shared <= '0;
            b_modified <= '0;
        end else begin
            if (fill_req) begin
                p_valid[fill_idx] <= 1'h1;
                p_shared[fill_idx] <= fill_shared;
                b_valid[fill_idx] <= 1'h1;
                b_shared[fill_idx] <= fill_shared;
                b_modified[fill_idx] <= fill_modified;
            end else if (flush_req) begin
                p_valid[flush_index] <= 1'h0;
                b_valid[flush_index] <= 1'h0;
                b_modified[flush_index] <= 1'h0;
            end
            // Write hit makes the line exclusive modified
            if (cb_write_hit) begin
                b_modified[p1_idx] <= 1'h1;
                b_shared[p1_idx] <= 1'h0;
                p_shared[p1_idx] <= 1'h0;
            end
            // Invalidating snoops drop both copies
            if (s_kill) begin
                p_valid[s1_idx] <= 1'h0;
                b_valid[s1_idx] <= 1'h0;
                b_modified[s1_idx] <= 1'h0;
            end else if (s_share) begin
                p_shared[s1_idx] <= 1'h1;
                b_shared[s1_idx] <= 1'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Processor side answers one cycle after the tag data
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            proc_done <= 1'h0;
            proc_tag_hit <= 1'h0;
            proc_access_ok <= 1'h0;
            proc_line_shared <= 1'h0;
            mem_write_req <= 1'h0;
            line_invalidate_req <= 1'h0;
            writeback_req <= 1'h0;
            writeback_index <= '0;
        end else begin
            proc_done <= p1_vld;
            proc_tag_hit <= p_hit;
            proc_access_ok <= p_ok;
            proc_line_shared <= p_hit && copy_back_mode && p_shared[p1_idx];
            mem_write_req <= wt_write;
            line_invalidate_req <= cb_write_shared;
            // owner writes the modified line back
            writeback_req <= evict_dirty;
            writeback_index <= evict_idx;
        end
    end

    // Snoop answers land in cycle A+2
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            snoop_done <= 1'h0;
            snoop_hit <= 1'h0;
            bus_shared_n <= MSH_IDLE;
            snoop_owner <= 1'h0;
            snoop_state <= COH_INVALID;
        end else begin
            snoop_done <= s1_vld;
            snoop_hit <= s_hit;
            // shared line driven low at A+2
            bus_shared_n <= s_share ? MSH_ASSERTED : MSH_IDLE;
            snoop_owner <= s_owner;
            snoop_state <= s_state;
        end
    end

endmodule

// file: hw/tag_dir_pkg.sv
package tag_dir_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ENTRIES = 2048;              // Lines per tag array
    localparam int INDEX_W = 11;                // Line index width
    localparam int VTAG_W = 16;                 // Virtual tag width
    localparam int CTX_W = 12;                  // Context number width
    localparam int PTAG_W = 24;                 // Physical tag width
    localparam int ACC_W = 3;                   // Access-level field width

    // ------------------------------------------------------------
    // Address field positions
    // ------------------------------------------------------------
    localparam int VA_W = 32;                   // Virtual address width
    localparam int VA_IDX_LO = 5;               // Line select, low bit
    localparam int VA_IDX_HI = 15;              // Line select, high bit
    localparam int VA_TAG_LO = 16;              // Virtual tag, low bit
    localparam int VA_TAG_HI = 31;              // Virtual tag, high bit
    localparam int MAD_W = 64;                  // Bus address cycle width
    localparam int MAD_SUPER_LO = 46;           // Superset virtual bits, low
    localparam int MAD_SUPER_HI = 49;           // Superset virtual bits, high
    localparam int MAD_PIDX_LO = 5;             // Physical index bits, low
    localparam int MAD_PIDX_HI = 11;            // Physical index bits, high
    localparam int PA_TAG_LO = 12;              // Physical tag, low bit
    localparam int PA_TAG_HI = 35;              // Physical tag, high bit

    // ------------------------------------------------------------
    // Processor-side entry layout {S, context, tag}
    // ------------------------------------------------------------
    localparam int PENTRY_W = 29;               // Stored entry width
    localparam int PE_TAG_LO = 0;
    localparam int PE_TAG_HI = 15;
    localparam int PE_CTX_LO = 16;
    localparam int PE_CTX_HI = 27;
    localparam int PE_S_BIT = 28;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [ACC_W-1:0] ACC_SUPER_A = 3'h6;  // Supervisor-only level
    localparam logic [ACC_W-1:0] ACC_SUPER_B = 3'h7;  // Supervisor-only level
    localparam logic MSH_ASSERTED = 1'h0;             // Shared line driven low
    localparam logic MSH_IDLE = 1'h1;                 // Shared line released

    // Snooped coherent transaction kinds
    typedef enum logic [1:0] {
        SNOOP_READ = 2'h0,
        SNOOP_READ_INV = 2'h1,
        SNOOP_INV = 2'h2,
        SNOOP_WRITE_INV = 2'h3
    } snoop_kind_t;

    // Line states, Gray along the usual fill, write, share path
    typedef enum logic [2:0] {
        COH_INVALID = 3'h0,
        COH_EXCL_CLEAN = 3'h1,
        COH_EXCL_MOD = 3'h3,
        COH_SHARED_MOD = 3'h2,
        COH_SHARED_CLEAN = 3'h6
    } coh_state_t;

endpackage

// file: hw/tag_mem.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Tag storage, one write port, one registered read port
// ------------------------------------------------------------
module tag_mem #(
    parameter int WIDTH = 24,                   // Entry width
    parameter int DEPTH = 2048,                 // Entry count
    parameter int AW = 11                       // Address width
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    // No reset on the array: validity lives in flops outside
    logic [WIDTH-1:0] mem [DEPTH];

    // Write, and read old data on a same-address collision
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

// file: test/tlb_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Translation buffer stand-in on the processor side
// ------------------------------------------------------------
module tlb_model
    import tag_dir_pkg::*;
(
    input wire logic sys_clk,
    input wire logic proc_req,
    input wire logic [VA_W-1:0] proc_va,
    output logic tlb_hit,
    output logic tlb_perm_ok
);
    // Answer a cycle after lookup: nibble F misses, nibble E lacks permission;
    // idle cycles toggle, so a late sample fails
    // translation and permission
    always @(posedge sys_clk) begin
        if (proc_req) begin
            tlb_hit <= (proc_va[31:28] != 4'hF);
            tlb_perm_ok <= (proc_va[27:24] != 4'hE);
        end else begin
            tlb_hit <= ~tlb_hit;
            tlb_perm_ok <= ~tlb_perm_ok;
        end
    end
endmodule

// file: test/tag_directory_props.sv
`timescale 1ns/1ns
module tag_directory_props
    import tag_dir_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic copy_back_mode,
    input wire logic proc_req,
    input wire logic proc_write,
    input wire logic tlb_hit,
    input wire logic tlb_perm_ok,
    input wire logic snoop_req,
    input wire logic [1:0] snoop_type,
    input wire logic proc_done,
    input wire logic proc_tag_hit,
    input wire logic proc_access_ok,
    input wire logic proc_line_shared,
    input wire logic mem_write_req,
    input wire logic line_invalidate_req,
    input wire logic snoop_done,
    input wire logic snoop_hit,
    input wire logic bus_shared_n,
    input wire logic snoop_owner,
    input wire logic [2:0] snoop_state
);
    // ------------------------------------------------------------
    // Timing and coherency relations at the ports
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_lookup_two_cycles: assert property (proc_req |-> ##2 proc_done)
        else $error("lookup answer late");
    a_access_needs_all: assert property (proc_done |-> proc_access_ok ==
        (proc_tag_hit && $past(tlb_hit) && $past(tlb_perm_ok)))
        else $error("access ok mismatch");
    a_snoop_two_cycles: assert property (snoop_req |-> ##2 snoop_done)
        else $error("snoop answer late");
    a_hit_state_valid: assert property (snoop_done && snoop_hit |->
        snoop_state != COH_INVALID)
        else $error("hit on invalid line");
    // Shared line driven exactly on copy-back coherent read hits
    a_read_hit_shares: assert property ((bus_shared_n == MSH_ASSERTED) ==
        (snoop_done && snoop_hit && copy_back_mode && $past(snoop_type, 2) == SNOOP_READ))
        else $error("shared line mismatch");
    a_owner_modified: assert property (snoop_owner |-> snoop_done && copy_back_mode &&
        snoop_state inside {COH_EXCL_MOD, COH_SHARED_MOD})
        else $error("owner on clean line");
    a_wt_two_states: assert property (snoop_done && !copy_back_mode |->
        snoop_state inside {COH_INVALID, COH_EXCL_CLEAN} && !snoop_owner)
        else $error("write-through state");
    a_wt_mem_write: assert property (proc_done && !copy_back_mode |-> mem_write_req ==
        ($past(proc_write, 2) && $past(tlb_hit) && $past(tlb_perm_ok)))
        else $error("memory write mismatch");
    a_cb_keeps_local: assert property (copy_back_mode |-> !mem_write_req)
        else $error("copy-back memory write");
    a_wt_no_shared: assert property (proc_done && !copy_back_mode |->
        !proc_line_shared && !line_invalidate_req)
        else $error("write-through sharing");

    c_owner: cover property (snoop_owner);
    c_shared: cover property (bus_shared_n == MSH_ASSERTED);
    c_hit_ok: cover property (proc_done && proc_access_ok);
    c_invalidate: cover property (line_invalidate_req);
endmodule

bind tag_directory tag_directory_props i_tag_directory_props (.sys_clk, .sys_rst,
    .copy_back_mode, .proc_req, .proc_write, .tlb_hit, .tlb_perm_ok, .snoop_req,
    .snoop_type, .proc_done, .proc_tag_hit, .proc_access_ok, .proc_line_shared,
    .mem_write_req, .line_invalidate_req, .snoop_done, .snoop_hit, .bus_shared_n,
    .snoop_owner, .snoop_state);

// file: test/tag_directory_bench.sv
`timescale 1ns/1ns
module tag_directory_bench
    import tag_dir_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic sys_clk = 1'h0, sys_rst = 1'h1, copy_back_mode = 1'h1;
    logic proc_req = 1'h0, proc_write = 1'h0, proc_super = 1'h0;
    logic [VA_W-1:0] proc_va = 32'h0, fill_va = 32'h0;
    logic [CTX_W-1:0] context_number = 12'h0, fill_context = 12'h0;
    logic fill_req = 1'h0, fill_write = 1'h0, fill_bus_shared_n = 1'h1;
    logic [PTAG_W-1:0] fill_pa_tag = 24'h0;
    logic [ACC_W-1:0] fill_acc_level = 3'h0;
    logic flush_req = 1'h0, snoop_req = 1'h0;
    logic [INDEX_W-1:0] flush_index = 11'h0, writeback_index;
    logic [MAD_W-1:0] snoop_mad = 64'h0;
    logic [1:0] snoop_type = 2'h0;
    logic tlb_hit, tlb_perm_ok, proc_done, proc_tag_hit, proc_access_ok, proc_line_shared;
    logic mem_write_req, line_invalidate_req, writeback_req, snoop_done, snoop_hit;
    logic bus_shared_n, snoop_owner;
    logic [2:0] snoop_state;
    int failures = 0, checks_done = 0;
    // Lines used below
    localparam logic [31:0] VA_A = 32'h12341A40, VA_B = 32'hF0562000;
    localparam logic [31:0] VA_S = 32'h07774420, VA_M = 32'h03336660;
    localparam logic [23:0] PT_A = 24'hABCDE1, PT_M = 24'h0F0F33;

    always #2 sys_clk = ~sys_clk;

    tag_directory i_tag_directory (.sys_clk, .sys_rst, .copy_back_mode, .proc_req, .proc_va,
        .proc_write, .proc_super, .context_number, .tlb_hit, .tlb_perm_ok, .fill_req,
        .fill_va, .fill_pa_tag, .fill_context, .fill_acc_level, .fill_write,
        .fill_bus_shared_n, .flush_req, .flush_index, .snoop_req, .snoop_mad, .snoop_type,
        .proc_done, .proc_tag_hit, .proc_access_ok, .proc_line_shared, .mem_write_req,
        .line_invalidate_req, .writeback_req, .writeback_index, .snoop_done, .snoop_hit,
        .bus_shared_n, .snoop_owner, .snoop_state);
    tlb_model i_tlb_model (.sys_clk, .proc_req, .proc_va, .tlb_hit, .tlb_perm_ok);

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Lookup; mode {write, super}, exp {hit, ok, shared, mem write, invalidate}
    task automatic lookup(input logic [31:0] va, input logic [1:0] mode,
            input logic [11:0] ctx, input logic [4:0] exp);
        @(posedge sys_clk);
        proc_req <= 1'h1;
        proc_va <= va;
        proc_write <= mode[1];
        proc_super <= mode[0];
        context_number <= ctx;
        @(posedge sys_clk);
        proc_req <= 1'h0;
        @(posedge sys_clk);
        #1 check({proc_done, proc_tag_hit, proc_access_ok, proc_line_shared, mem_write_req,
            line_invalidate_req}, {1'h1, exp});
    endtask

    // Snoop phase, index bits from va; exp {hit, shared, owner}; state 7 skips
    task automatic snoop(input logic [31:0] va, input logic [23:0] pt, input logic [1:0] ty,
            input logic [2:0] exp, input logic [2:0] st);
        @(posedge sys_clk);
        snoop_req <= 1'h1;
        snoop_type <= ty;
        snoop_mad <= {14'h0, va[15:12], 10'h0, pt, va[11:5], 5'h0};
        @(posedge sys_clk);
        snoop_req <= 1'h0;
        @(posedge sys_clk);
        #1 check({snoop_done, snoop_hit, bus_shared_n == MSH_ASSERTED, snoop_owner},
            {1'h1, exp});
        if (st != 3'h7) check(snoop_state, st);
    endtask

    task automatic fill(input logic [31:0] va, input logic [23:0] pt, input logic [11:0] ctx,
            input logic [2:0] acc, input logic wr, input logic shn);
        @(posedge sys_clk);
        fill_req <= 1'h1;
        fill_va <= va;
        fill_pa_tag <= pt;
        fill_context <= ctx;
        fill_acc_level <= acc;
        fill_write <= wr;
        fill_bus_shared_n <= shn;
        @(posedge sys_clk);
        fill_req <= 1'h0;
    endtask

    // Flush and count write-back pulses naming this line
    task automatic flush(input logic [10:0] idx, input logic [31:0] wb);
        int seen;
        seen = 0;
        @(posedge sys_clk);
        flush_req <= 1'h1;
        flush_index <= idx;
        @(posedge sys_clk);
        flush_req <= 1'h0;
        for (int i = 0; i < 3; i++) begin
            #1 if (writeback_req === 1'h1 && writeback_index === idx) seen++;
            @(posedge sys_clk);
        end
        check(seen, wb);
    endtask

    task automatic close_out();
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        #100000;
        failures++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'h0;
        lookup(VA_A, 2'h0, 12'h005, 5'h00);
        snoop(VA_A, PT_A, SNOOP_READ, 3'h0, COH_INVALID);
        fill(VA_A, PT_A, 12'h005, 3'h2, 1'h0, 1'h1);
        lookup(VA_A, 2'h0, 12'h005, 5'h18);
        lookup(VA_A | 32'h1F, 2'h0, 12'h005, 5'h18);
        lookup(VA_A ^ 32'h20, 2'h0, 12'h005, 5'h00);
        lookup(VA_A, 2'h0, 12'h006, 5'h00);
        lookup(VA_A ^ 32'h10000, 2'h0, 12'h005, 5'h00);
        snoop(VA_A, PT_A ^ 24'h1, SNOOP_READ, 3'h0, 3'h7);
        snoop(VA_A ^ 32'h1000, PT_A, SNOOP_READ, 3'h0, COH_INVALID);
        snoop(VA_A, PT_A, SNOOP_READ, 3'h6, COH_EXCL_CLEAN);
        lookup(VA_A, 2'h0, 12'h005, 5'h1C);
        snoop(VA_A, PT_A, SNOOP_READ, 3'h6, COH_SHARED_CLEAN);
        fill(VA_B, PT_M, 12'h005, 3'h2, 1'h0, 1'h1);
        lookup(VA_B, 2'h0, 12'h005, 5'h10);
        for (int acc = 5; acc < 8; acc++) begin
            fill(VA_S, PT_M, 12'h003, acc[2:0], 1'h0, 1'h1);
            lookup(VA_S, 2'h1, 12'h009, {acc > 5, acc > 5, 3'h0});
            lookup(VA_S, 2'h0, 12'h009, 5'h00);
        end
        fill(VA_M, PT_M, 12'h001, 3'h2, 1'h1, 1'h1);
        snoop(VA_M, PT_M, SNOOP_READ, 3'h7, COH_EXCL_MOD);
        snoop(VA_M, PT_M, SNOOP_READ_INV, 3'h5, COH_SHARED_MOD);
        snoop(VA_M, PT_M, SNOOP_READ, 3'h0, COH_INVALID);
        for (int k = 2; k < 4; k++) begin
            fill(VA_M, PT_M, 12'h001, 3'h2, 1'h0, 1'h1);
            snoop(VA_M, PT_M, k[1:0], 3'h4, COH_EXCL_CLEAN);
            lookup(VA_M, 2'h0, 12'h001, 5'h00);
        end
        fill(VA_M, PT_M, 12'h001, 3'h2, 1'h1, 1'h1);
        flush(VA_M[15:5], 1);
        lookup(VA_M, 2'h0, 12'h001, 5'h00);
        fill(VA_A, PT_A, 12'h005, 3'h2, 1'h0, 1'h0);
        lookup(VA_A, 2'h2, 12'h005, 5'h1D);
        // Processor lookup and snoop in the same cycles
        fork
            lookup(VA_A, 2'h0, 12'h005, 5'h18);
            snoop(VA_A, PT_A, SNOOP_READ, 3'h7, COH_EXCL_MOD);
        join
        flush(VA_A[15:5], 1);
        // Write-through: only valid and invalid, every translated write to memory
        repeat (4) @(posedge sys_clk);
        copy_back_mode <= 1'h0;
        fill(VA_A, PT_A, 12'h005, 3'h2, 1'h0, 1'h0);
        snoop(VA_A, PT_A, SNOOP_READ, 3'h4, COH_EXCL_CLEAN);
        lookup(VA_A, 2'h2, 12'h005, 5'h1A);
        lookup(VA_A, 2'h2, 12'h006, 5'h02);
        lookup(VA_B, 2'h2, 12'h006, 5'h00);
        flush(VA_A[15:5], 0);
        close_out();
    end
endmodule
